// file: logic/tlsq_pkg.sv
// package: constants and types for the torque limit and status qualifier
package tlsq_pkg;

  // ----------------------------------------------------------------
  // parameter table indices (tool port address)
  // ----------------------------------------------------------------
  localparam int NUM_PARAMS = 13;
  localparam logic [3:0] IDX_FWD2 = 4'h0;
  localparam logic [3:0] IDX_REV2 = 4'h1;
  localparam logic [3:0] IDX_FOLLOW_TIME = 4'h2;
  localparam logic [3:0] IDX_FOLLOW_LEVEL = 4'h3;
  localparam logic [3:0] IDX_INPOS_RANGE = 4'h4;
  localparam logic [3:0] IDX_INPOS_TIME = 4'h5;
  localparam logic [3:0] IDX_SPEED_RANGE = 4'h6;
  localparam logic [3:0] IDX_SPEED_TIME = 4'h7;
  localparam logic [3:0] IDX_MAX_ONE = 4'h8;
  localparam logic [3:0] IDX_FUNC_SELECT = 4'h9;
  localparam logic [3:0] IDX_TRAVEL_DIR = 4'ha;
  localparam logic [3:0] IDX_POL_REFLECT = 4'hb;
  localparam logic [3:0] IDX_SWITCH_EN = 4'hc;

  // ----------------------------------------------------------------
  // values after reset (torque in 0.1 % units)
  // ----------------------------------------------------------------
  localparam logic [31:0] TORQUE_FULL_SCALE = 32'h0000_2710; // 1000.0 %
  localparam logic [31:0] RESET_FUNC_SELECT = 32'h0000_0010;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [31:0] FOLLOW_LEVEL_OFF = 32'h0fff_ffff;
  localparam logic [31:0] INPOS_RANGE_MAX = 32'hffff_ffff;
  localparam logic [31:0] TIME_MAX_MS = 32'h0000_ffff;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MAX_ONE_SEL_LSB = 4; // digit 1 of function select
  localparam int CW_FWD_SWITCH_BIT = 11;
  localparam int CW_REV_SWITCH_BIT = 12;
  localparam int SW_TARGET_REACHED_BIT = 10;
  localparam int SW_FOLLOW_ERR_BIT = 13;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_IN_NS = 1000000;
  localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_CSP, MODE_CSV, MODE_CST, MODE_PP, MODE_PV, MODE_TQ, MODE_PT, MODE_JOG
  } op_mode_t;

  // cyclic objects from the motion controller, with one mapped flag each
  typedef struct packed {
    logic [31:0] fwd_torque_limit_second;
    logic [31:0] rev_torque_limit_second;
    logic [31:0] max_torque_limit_one;
    logic [31:0] follow_err_filter_time;
    logic [31:0] inpos_second_filter_time;
    logic [31:0] speed_reach_second_filter_time;
  } cyc_obj_t;

  typedef struct packed {
    logic fwd2;
    logic rev2;
    logic max1;
    logic follow_time;
    logic inpos_time;
    logic speed_time;
  } cyc_map_t;

endpackage

// file: logic/torque_limit_status_qualifier.sv
// module: torque limit selection and status-word qualification for one axis
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - second forward/reverse limits accept 0.0..1000.0 %, reset to 1000.0 %
// - forward second limit governs ccw power running and cw regeneration
// - reverse second limit governs cw power running and ccw regeneration
// - a zero limit setting yields no torque in its direction
// - limits above motor maximum torque clamp to motor maximum
// - travel direction and polarity reflection swap the second-limit objects
// - status bit 13 sets after droop at/above level for filter time
// - 28-bit all-ones following error level (0x0fffffff) disables the following error output
// - following error evaluated only in csp, pp, point table, jog
// - status bit 10 sets after position error in range for filter time
// - in-position qualification only in pp, point table and jog
// - in pv mode bit 10 sets after speed error in range for time
// - in-position and speed filter times are 0..65535 ms, reset zero
// - function select digit 1 enables max torque limit 1, reset enabled
// - disabled max limit 1 ignored; readback returns motor maximum
// - enabled max limit 1 clamps torque, 0.0..1000.0 %, reset 1000.0 %
// - cyclic controller writes override tool writes for mapped objects
// - switch enable: control bits 11/12 pick second limits over first
module torque_limit_status_qualifier #(
  parameter int CYCLES_PER_MS = tlsq_pkg::CYCLES_PER_MS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // engineering tool parameter port
  input wire logic tool_wr,
  input wire logic [3:0] tool_sel,
  input wire logic [31:0] tool_wdata,
  output logic [31:0] tool_rd_data,
  // cyclic objects from the controller
  input wire logic cyc_strobe,
  input wire tlsq_pkg::cyc_obj_t cyc_obj,
  input wire tlsq_pkg::cyc_map_t cyc_map,
  input wire logic [15:0] control_word,
  input wire tlsq_pkg::op_mode_t op_mode,
  // motor and loop measurements (magnitudes)
  input wire logic [15:0] motor_max_torque,
  input wire logic [15:0] fwd_torque_limit_first,
  input wire logic [15:0] rev_torque_limit_first,
  input wire logic [31:0] droop_pulses,
  input wire logic [31:0] position_error,
  input wire logic [31:0] speed_error,
  // limit and status results
  output logic [15:0] fwd_torque_limit,
  output logic [15:0] rev_torque_limit,
  output logic [15:0] status_word
);
  import tlsq_pkg::*;

  // a rate below two cycles leaves the tick counter with no bits
  if (CYCLES_PER_MS < 2) begin : g_bad_rate
    $error("CYCLES_PER_MS must be at least 2");
  end

  // ----------------------------------------------------------------
  // parameter storage
  // ----------------------------------------------------------------
  logic [31:0] param_q [NUM_PARAMS];
  logic [31:0] cyc_val [NUM_PARAMS];
  logic cyc_hit [NUM_PARAMS];
  logic obj_swap;

  assign obj_swap = param_q[IDX_TRAVEL_DIR][0] & param_q[IDX_POL_REFLECT][0];

  // cyclic routing per table entry
  always_comb begin
    for (int i = 0; i < NUM_PARAMS; i++) begin
      cyc_val[i] = RESET_ZERO;
      cyc_hit[i] = 1'b0;
    end
    cyc_val[IDX_FWD2] = cyc_obj.fwd_torque_limit_second;
    cyc_val[IDX_REV2] = cyc_obj.rev_torque_limit_second;
    cyc_val[IDX_MAX_ONE] = cyc_obj.max_torque_limit_one;
    cyc_val[IDX_FOLLOW_TIME] = cyc_obj.follow_err_filter_time;
    cyc_val[IDX_INPOS_TIME] = cyc_obj.inpos_second_filter_time;
    cyc_val[IDX_SPEED_TIME] = cyc_obj.speed_reach_second_filter_time;
    // swapped second-limit mapping: the positive object feeds reverse
    if (obj_swap) begin
      cyc_val[IDX_FWD2] = cyc_obj.rev_torque_limit_second;
      cyc_val[IDX_REV2] = cyc_obj.fwd_torque_limit_second;
      cyc_hit[IDX_FWD2] = cyc_strobe & cyc_map.rev2;
      cyc_hit[IDX_REV2] = cyc_strobe & cyc_map.fwd2;
    end else begin
      cyc_hit[IDX_FWD2] = cyc_strobe & cyc_map.fwd2;
      cyc_hit[IDX_REV2] = cyc_strobe & cyc_map.rev2;
    end
    cyc_hit[IDX_MAX_ONE] = cyc_strobe & cyc_map.max1;
    cyc_hit[IDX_FOLLOW_TIME] = cyc_strobe & cyc_map.follow_time;
    cyc_hit[IDX_INPOS_TIME] = cyc_strobe & cyc_map.inpos_time;
    cyc_hit[IDX_SPEED_TIME] = cyc_strobe & cyc_map.speed_time;
  end

  // value of each entry after reset; called with a genvar, so it folds to a constant
  function automatic logic [31:0] reset_value(input int idx);
    logic [31:0] r;
    r = RESET_ZERO;
    if (idx == int'(IDX_FWD2) || idx == int'(IDX_REV2)) begin
      r = TORQUE_FULL_SCALE;
    end
    if (idx == int'(IDX_MAX_ONE)) begin
      r = TORQUE_FULL_SCALE;
    end
    if (idx == int'(IDX_FOLLOW_LEVEL)) begin
      r = FOLLOW_LEVEL_OFF;
    end
    if (idx == int'(IDX_INPOS_RANGE)) begin
      r = INPOS_RANGE_MAX;
    end
    if (idx == int'(IDX_FUNC_SELECT)) begin
      r = RESET_FUNC_SELECT;
    end
    return r;
  endfunction

  // range limit applied on every write: torque and time fields saturate
  function automatic logic [31:0] sat_value(input logic [3:0] idx, input logic [31:0] v);
    logic [31:0] r;
    r = v;
    if ((idx == IDX_FWD2 || idx == IDX_REV2 || idx == IDX_MAX_ONE) && v > TORQUE_FULL_SCALE) begin
      r = TORQUE_FULL_SCALE;
    end
    if ((idx == IDX_FOLLOW_TIME || idx == IDX_INPOS_TIME || idx == IDX_SPEED_TIME) && v > TIME_MAX_MS) begin
      r = TIME_MAX_MS;
    end
    return r;
  endfunction

  // one storage word per entry; cyclic write beats a tool write in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PARAMS; gi++) begin : g_param
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          param_q[gi] <= reset_value(gi);
        end else if (cyc_hit[gi]) begin
          param_q[gi] <= sat_value(4'(gi), cyc_val[gi]);
        end else if (tool_wr && tool_sel == 4'(gi)) begin
          param_q[gi] <= sat_value(4'(gi), tool_wdata);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // torque limit selection
  // ----------------------------------------------------------------
  logic max_one_enabled;
  logic [15:0] max_one;
  logic [15:0] fwd_pick;
  logic [15:0] rev_pick;
  logic [15:0] next_fwd_limit;
  logic [15:0] next_rev_limit;

  assign max_one_enabled = param_q[IDX_FUNC_SELECT][MAX_ONE_SEL_LSB +: 4] == 4'h1;
  assign max_one = param_q[IDX_MAX_ONE][15:0];

  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  // first or second limit, then the smaller of that, max limit 1 and motor max
  always_comb begin
    fwd_pick = fwd_torque_limit_first;
    rev_pick = rev_torque_limit_first;
    if (param_q[IDX_SWITCH_EN][0] && control_word[CW_FWD_SWITCH_BIT]) begin
      fwd_pick = param_q[IDX_FWD2][15:0];
    end
    if (param_q[IDX_SWITCH_EN][0] && control_word[CW_REV_SWITCH_BIT]) begin
      rev_pick = param_q[IDX_REV2][15:0];
    end
    next_fwd_limit = min16(fwd_pick, motor_max_torque);
    next_rev_limit = min16(rev_pick, motor_max_torque);
    if (max_one_enabled) begin
      next_fwd_limit = min16(next_fwd_limit, max_one);
      next_rev_limit = min16(next_rev_limit, max_one);
    end
  end

  // forward output serves ccw power / cw regen, reverse the opposite;
  // a zero setting passes straight through min, so zero means no torque
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fwd_torque_limit <= 16'h0000;
      rev_torque_limit <= 16'h0000;
    end else begin
      fwd_torque_limit <= next_fwd_limit;
      rev_torque_limit <= next_rev_limit;
    end
  end

  // tool readback; max limit 1 reads as motor max while disabled
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tool_rd_data <= 32'h0000_0000;
    end else if (tool_sel == IDX_MAX_ONE && !max_one_enabled) begin
      tool_rd_data <= {16'h0000, motor_max_torque};
    end else if (tool_sel < 4'(NUM_PARAMS)) begin
      tool_rd_data <= param_q[tool_sel];
    end else begin
      tool_rd_data <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  localparam int TICK_W = $clog2(CYCLES_PER_MS);
  logic [TICK_W-1:0] tick_cnt;
  logic ms_tick;

  // long count kept as a parameter so simulation can shorten it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tick_cnt <= '0;
      ms_tick <= 1'b0;
    end else if (tick_cnt == TICK_W'(CYCLES_PER_MS - 1)) begin
      tick_cnt <= '0;
      ms_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      ms_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // filter timers: 0 following error, 1 in-position, 2 speed reached
  // ----------------------------------------------------------------
  logic mode_follow;
  logic mode_inpos;
  logic mode_speed;
  logic inpos_always;
  logic [2:0] cond;
  logic [15:0] filt_time [3];
  logic [2:0] qual;

  assign mode_follow = op_mode == MODE_CSP || op_mode == MODE_PP ||
                       op_mode == MODE_PT || op_mode == MODE_JOG;
  assign mode_inpos = op_mode == MODE_PP || op_mode == MODE_PT || op_mode == MODE_JOG;
  assign mode_speed = op_mode == MODE_PV;
  assign inpos_always = param_q[IDX_INPOS_RANGE] == INPOS_RANGE_MAX;

  // full 32-bit level compare; the 28-bit all-ones code blocks the output
  assign cond[0] = mode_follow && param_q[IDX_FOLLOW_LEVEL] != FOLLOW_LEVEL_OFF &&
                   droop_pulses >= param_q[IDX_FOLLOW_LEVEL];
  assign cond[1] = mode_inpos && position_error <= param_q[IDX_INPOS_RANGE];
  assign cond[2] = mode_speed && speed_error <= param_q[IDX_SPEED_RANGE];
  assign filt_time[0] = param_q[IDX_FOLLOW_TIME][15:0];
  assign filt_time[1] = param_q[IDX_INPOS_TIME][15:0];
  assign filt_time[2] = param_q[IDX_SPEED_TIME][15:0];

  // first tick may come at once, so n ms waits n+1 ticks: hold is n..n+1 ms
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filter
      logic [16:0] ms_cnt; // one bit more so a 65535 ms setting still reaches n+1
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          ms_cnt <= 17'h00000;
          qual[gi] <= 1'b0;
        end else if (!cond[gi]) begin
          ms_cnt <= 17'h00000;
          qual[gi] <= 1'b0;
        end else begin
          if (ms_tick && ms_cnt <= {1'b0, filt_time[gi]}) begin
            ms_cnt <= ms_cnt + 17'h00001;
          end
          qual[gi] <= filt_time[gi] == 16'h0000 || ms_cnt > {1'b0, filt_time[gi]};
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  logic [15:0] next_status;

  always_comb begin
    next_status = 16'h0000;
    next_status[SW_FOLLOW_ERR_BIT] = qual[0];
    if (mode_inpos) begin
      next_status[SW_TARGET_REACHED_BIT] = qual[1] | inpos_always;
    end else if (mode_speed) begin
      next_status[SW_TARGET_REACHED_BIT] = qual[2];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status_word <= 16'h0000;
    end else begin
      status_word <= next_status;
    end
  end

endmodule

`default_nettype wire

// file: dv/tlsq_chk_sva.sv
// checker: port-level properties of the torque limit and status qualifier
`timescale 1ns/1ps
`default_nettype none
module tlsq_chk
  import tlsq_pkg::*;
#(parameter int CYCLES_PER_MS = 4) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // causes
  input wire logic [15:0] control_word,
  input wire tlsq_pkg::op_mode_t op_mode,
  input wire logic [15:0] motor_max_torque,
  input wire logic [15:0] fwd_torque_limit_first,
  input wire logic [15:0] rev_torque_limit_first,
  // results
  input wire logic [15:0] fwd_torque_limit,
  input wire logic [15:0] rev_torque_limit,
  input wire logic [15:0] status_word
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----
  // limits are upper bounds: the motor and first caps one cycle after their inputs, full scale in every cycle
  // ----
  a_fwd_motor_cap: assert property (1'b1 |=> fwd_torque_limit <= $past(motor_max_torque))
    else $error("fwd limit above motor maximum");
  a_rev_motor_cap: assert property (1'b1 |=> rev_torque_limit <= $past(motor_max_torque))
    else $error("rev limit above motor maximum");
  a_fwd_first_cap: assert property (!control_word[11] |=> fwd_torque_limit <= $past(fwd_torque_limit_first))
    else $error("fwd limit above first limit");
  a_rev_first_cap: assert property (!control_word[12] |=> rev_torque_limit <= $past(rev_torque_limit_first))
    else $error("rev limit above first limit");
  a_fwd_full_scale: assert property (fwd_torque_limit <= 16'h2710)
    else $error("fwd limit above full scale");
  a_rev_full_scale: assert property (rev_torque_limit <= 16'h2710)
    else $error("rev limit above full scale");
  // either latency of the status path is accepted, a wrong mode in both is not
  a_follow_mode: assert property (status_word[13] |->
    ($past(op_mode) inside {MODE_CSP, MODE_PP, MODE_PT, MODE_JOG}) ||
    ($past(op_mode, 2) inside {MODE_CSP, MODE_PP, MODE_PT, MODE_JOG}))
    else $error("following error in wrong mode");
  a_reach_mode: assert property (status_word[10] |->
    ($past(op_mode) inside {MODE_PP, MODE_PV, MODE_PT, MODE_JOG}) ||
    ($past(op_mode, 2) inside {MODE_PP, MODE_PV, MODE_PT, MODE_JOG}))
    else $error("target reached in wrong mode");
endmodule
bind torque_limit_status_qualifier tlsq_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk_u (.sys_clk, .reset,
  .control_word, .op_mode, .motor_max_torque, .fwd_torque_limit_first, .rev_torque_limit_first,
  .fwd_torque_limit, .rev_torque_limit, .status_word);
`default_nettype wire

// file: dv/tlsq_ctrl_model.sv
// partner: motion controller model issuing cyclic object frames
`timescale 1ns/1ps
`default_nettype none
module tlsq_ctrl_model
  import tlsq_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // cyclic objects toward the axis
  output logic cyc_strobe,
  output tlsq_pkg::cyc_obj_t cyc_obj,
  output tlsq_pkg::cyc_map_t cyc_map
);
  // idle: no frame, nothing mapped, object lines carry junk
  initial begin
    cyc_strobe = 1'b0;
    cyc_obj = '1;
    cyc_map = '0;
  end
  // one frame per strobe; mapping stays as a level between frames
  task automatic send(input cyc_obj_t o, input cyc_map_t m);
    @(posedge sys_clk);
    #1;
    cyc_strobe = 1'b1;
    cyc_obj = o;
    cyc_map = m;
    @(posedge sys_clk);
    #1;
    cyc_strobe = 1'b0;
    cyc_obj = ~o; // stale values must never look valid
  endtask
endmodule
`default_nettype wire

// file: dv/torque_limit_status_qualifier_tb_top.sv
// testbench: limit table, cyclic override, status filters, reset values
`timescale 1ns/1ps
`default_nettype none
module torque_limit_status_qualifier_tb_top;
  import tlsq_pkg::*;
  typedef struct packed {logic [15:0] mm, f1, r1, cw, ef, er;} lim_row_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic tool_wr = 1'b0;
  logic [3:0] tool_sel = 4'h0;
  logic [31:0] tool_wdata = 32'h0;
  logic [31:0] tool_rd_data;
  logic cyc_strobe;
  cyc_obj_t cyc_obj;
  cyc_map_t cyc_map;
  logic [15:0] control_word = 16'h0;
  op_mode_t op_mode = MODE_CSP;
  logic [15:0] motor_max_torque = 16'h0bb8;
  logic [15:0] fwd_torque_limit_first = 16'h07d0;
  logic [15:0] rev_torque_limit_first = 16'h05dc;
  logic [31:0] droop_pulses = 32'h0;
  logic [31:0] position_error = '1;
  logic [31:0] speed_error = '1;
  logic [15:0] fwd_torque_limit;
  logic [15:0] rev_torque_limit;
  logic [15:0] status_word;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  cyc_obj_t obj = '0;
  lim_row_t rows[6] = '{'{16'h0bb8, 16'h07d0, 16'h05dc, 16'h0000, 16'h07d0, 16'h05dc},
    '{16'h0bb8, 16'h07d0, 16'h05dc, 16'h0800, 16'h01f4, 16'h05dc},
    '{16'h0bb8, 16'h07d0, 16'h05dc, 16'h1000, 16'h07d0, 16'h02bc},
    '{16'h0bb8, 16'h07d0, 16'h05dc, 16'h1800, 16'h01f4, 16'h02bc},
    '{16'h03e8, 16'h07d0, 16'h1388, 16'h0000, 16'h03e8, 16'h03e8},
    '{16'h3a98, 16'h2ee0, 16'h0000, 16'h0000, 16'h2710, 16'h0000}};
  logic [31:0] rv[14] = '{TORQUE_FULL_SCALE, TORQUE_FULL_SCALE, RESET_ZERO, FOLLOW_LEVEL_OFF, INPOS_RANGE_MAX,
    RESET_ZERO, RESET_ZERO, RESET_ZERO, TORQUE_FULL_SCALE, RESET_FUNC_SELECT, RESET_ZERO, RESET_ZERO, RESET_ZERO,
    RESET_ZERO};
  // ----
  // clock, design, partner
  // ----
  always #5 sys_clk = ~sys_clk;
  torque_limit_status_qualifier #(.CYCLES_PER_MS(4)) dut_u (.sys_clk, .reset, .tool_wr, .tool_sel, .tool_wdata,
    .tool_rd_data, .cyc_strobe, .cyc_obj, .cyc_map, .control_word, .op_mode, .motor_max_torque,
    .fwd_torque_limit_first, .rev_torque_limit_first, .droop_pulses, .position_error, .speed_error,
    .fwd_torque_limit, .rev_torque_limit, .status_word);
  tlsq_ctrl_model ctrl_u (.sys_clk, .cyc_strobe, .cyc_obj, .cyc_map);
  // hang guard, about fifteen times the expected run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tool_write(input logic [3:0] sel, input logic [31:0] val);
    tick(1);
    tool_wr = 1'b1;
    tool_sel = sel;
    tool_wdata = val;
    tick(1);
    tool_wr = 1'b0;
  endtask
  task automatic tool_read(input logic [3:0] sel, input logic [31:0] exp, input string nm);
    tool_sel = sel;
    tick(2);
    cmp(nm, exp, tool_rd_data);
  endtask
  // bit must come up no sooner than lo and no later than hi cycles
  task automatic rise(input string nm, input int b, input int lo, input int hi);
    int i;
    i = 0;
    while (status_word[b] !== 1'b1 && i < hi) begin
      tick(1);
      i++;
    end
    cmp(nm, 32'h1, 32'(status_word[b]));
    cmp({nm, " delay"}, 32'h1, 32'(i >= lo));
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    tick(20);
    reset = 1'b0;
    tool_write(4'hc, 32'h1);
    tool_write(4'h0, 32'h1f4);
    tool_write(4'h1, 32'h2bc);
    foreach (rows[i]) begin
      {motor_max_torque, fwd_torque_limit_first, rev_torque_limit_first, control_word} = rows[i][95:32];
      tick(3);
      cmp("fwd limit", 32'(rows[i].ef), 32'(fwd_torque_limit));
      cmp("rev limit", 32'(rows[i].er), 32'(rev_torque_limit));
    end
    $display("limit table done");
    {motor_max_torque, fwd_torque_limit_first, rev_torque_limit_first, control_word} = rows[0][95:32];
    tool_write(4'h8, 32'h12c);
    tick(3);
    cmp("max one on", 32'h12c, 32'(fwd_torque_limit));
    tool_write(4'h9, 32'h0);
    tick(3);
    cmp("max one off", 32'h7d0, 32'(fwd_torque_limit));
    tool_read(4'h8, 32'h0bb8, "max one readback");
    tool_write(4'h9, 32'h10);
    tool_write(4'ha, 32'h1);
    tool_write(4'hb, 32'h1);
    obj.fwd_torque_limit_second = 32'h190;
    obj.rev_torque_limit_second = 32'h258;
    obj.max_torque_limit_one = 32'hfa;
    // tool write lands on the same edge as the frame and must lose
    fork
      ctrl_u.send(obj, '1);
      tool_write(4'h8, 32'h384);
    join
    tool_read(4'h0, 32'h258, "swapped fwd");
    tool_read(4'h1, 32'h190, "swapped rev");
    tool_read(4'h8, 32'hfa, "cyclic wins");
    $display("cyclic test done");
    droop_pulses = '1;
    tick(12);
    cmp("follow off", 32'h0, 32'(status_word[13]));
    droop_pulses = 32'h0;
    tool_write(4'h2, 32'h2);
    tool_write(4'h3, 32'h64);
    droop_pulses = 32'h64;
    rise("follow err", 13, 10, 15);
    droop_pulses = 32'h63;
    tick(2);
    cmp("follow drop", 32'h0, 32'(status_word[13]));
    droop_pulses = 32'h64;
    op_mode = MODE_PV;
    tick(16);
    cmp("follow mode", 32'h0, 32'(status_word[13]));
    // long in-position time: only the forced path can raise bit 10 here
    tool_write(4'h5, 32'h3e8);
    op_mode = MODE_PP;
    tick(3);
    cmp("target forced", 32'h1, 32'(status_word[10]));
    op_mode = MODE_CST;
    tick(3);
    cmp("target mode", 32'h0, 32'(status_word[10]));
    tool_write(4'h5, 32'h0);
    tool_write(4'h4, 32'ha);
    op_mode = MODE_PP;
    position_error = 32'h14;
    tick(4);
    cmp("target outside", 32'h0, 32'(status_word[10]));
    position_error = 32'ha;
    rise("target", 10, 2, 4);
    op_mode = MODE_PV;
    tool_write(4'h7, 32'h1);
    tool_write(4'h6, 32'h5);
    speed_error = 32'h10;
    tick(4);
    cmp("speed outside", 32'h0, 32'(status_word[10]));
    speed_error = 32'h3;
    rise("speed", 10, 6, 11);
    $display("status test done");
    reset = 1'b1;
    tick(2);
    cmp("limit in reset", 32'h0, 32'(fwd_torque_limit));
    reset = 1'b0;
    tool_write(4'hd, 32'h1);
    foreach (rv[i]) tool_read(4'(i), rv[i], "reset value");
    $display("reset test done");
    summarize();
  end
endmodule
`default_nettype wire
